// ---- design/lrp_pkg.sv ----
/*
  Constants and types of the two-wire register port of a nine-channel LED driver.
  Assumes one 10 MHz clock; the bus pins are sampled, never used as clocks.
*/
// Behaviour
// RULE1: Data line changes only while the serial clock is low.
// RULE2: Falling data with clock high is START; rising data is STOP.
// RULE3: Only the controller makes START and STOP, repeated START allowed.
// RULE4: Bus busy from START to STOP; repeated START restarts address reception.
// RULE5: Bytes are eight bits, most significant first, then an acknowledge bit.
// RULE6: Device pulls data low in the ninth pulse after each received byte.
// RULE7: Controller clocks the acknowledge pulse and releases data for it.
// RULE8: Controller leaves the last read byte unacknowledged.
// RULE9: First byte is seven-bit address plus direction, 0 write, 1 read.
// RULE10: Write sends register index, then data stored at that index.
// RULE11: Own address from strap pin: 32h-35h, alternate version 42h-45h.
// RULE12: Device also answers broadcast address 40h always.
// RULE13: Broadcast reads are valid only when all devices agree.
// RULE14: Address acknowledged only on match; otherwise data line released.
// RULE15: Index advances by one after each acknowledged written data byte.
// RULE16: Read: write index, repeated START with read bit, device returns byte.
// RULE17: Controller acknowledge advances index and sends next byte; nack ends read.
// RULE18: Auto-increment on after reset; cleared by enable bit in register 2Fh.
// RULE19: With auto-increment off the index stays the same across bytes.
package lrp_pkg;

  // ==========================================================
  // Addresses and register map
  localparam logic [6:0] BCAST_ADDR = 7'h40;
  localparam logic [6:0] BASE_ADDR  = 7'h32;
  localparam logic [6:0] ALT_ADDR   = 7'h42;
  localparam logic [7:0] GEN_SET    = 8'h2F;
  localparam int         STEP_BIT   = 0;
  localparam logic [7:0] GEN_RST    = 8'h01;
  localparam logic [7:0] STEP_ONE   = 8'h01;

  // ==========================================================
  // Pin sample vector layout and timing
  localparam int         PIN_SCL    = 0;
  localparam int         PIN_SDA    = 1;
  localparam int         PIN_ALT    = 2;
  localparam int         PIN_STRAP  = 3;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [1:0] LD_CYC     = 2'h2;
  localparam logic [1:0] CAP_DONE   = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6
  } lrp_state_t;

  typedef enum logic [1:0] {
    K_ADDR  = 2'h0,
    K_INDEX = 2'h1,
    K_DATA  = 2'h2
  } lrp_kind_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } lrp_wr_t;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic       scl_p;
    logic       sda_p;
    lrp_state_t state;
    lrp_kind_t  kind;
    logic [3:0] bit_cnt;
    logic [7:0] sr;
    logic       rw;
    logic       mack;
    logic       wrote;
    logic [7:0] index;
    logic [7:0] settings;
    logic       sda_oe;
    logic       scl_oe;
    logic       busy;
    logic [1:0] ld;
    logic       rd_req;
    logic [6:0] own;
    logic [1:0] cap;
    lrp_wr_t    out;
    logic       out_v;
    lrp_wr_t    skid;
    logic       skid_v;
  } lrp_regs_t;

endpackage

// ---- design/lrp_top.sv ----
/*
  Two-wire target port: framing, address match, index handling, write buffer,
  read fetch and the general settings register.
  Assumes the register file answers rd_data one cycle after rd_req and
  that the serial clock low phase lasts at least six mclk cycles.
*/
`timescale 1ns/100ps
module lrp_top
(
  input  wire logic           mclk,
  input  wire logic           arst_n,
  input  wire logic           scl_i,
  output logic                scl_o,
  output logic                scl_oe,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe,
  input  wire logic [1:0]     addr_strap,
  input  wire logic           alt_version,
  output logic                wr_valid,
  input  wire logic           wr_ready,
  output lrp_pkg::lrp_wr_t    wr_word,
  output logic                rd_req,
  output logic [7:0]          rd_addr,
  input  wire logic [7:0]     rd_data,
  output logic [7:0]          general_settings,
  output logic                busy
);

  // ==========================================================
  // State
  lrp_pkg::lrp_regs_t q;
  lrp_pkg::lrp_regs_t d;

  logic       scl;
  logic       sda;
  logic       rise_w;
  logic       fall_w;
  logic       start_w;
  logic       stop_w;
  logic       match_w;
  logic       full_w;
  logic       pop_w;
  logic       byte_w;
  logic [7:0] step_w;

  // ==========================================================
  // Pin edges, seen on the second sync stage only
  assign scl     = q.s2[lrp_pkg::PIN_SCL];
  assign sda     = q.s2[lrp_pkg::PIN_SDA];
  assign rise_w  = scl & ~q.scl_p;
  assign fall_w  = ~scl & q.scl_p;
  assign start_w = scl & q.scl_p & q.sda_p & ~sda;   // see RULE2
  assign stop_w  = scl & q.scl_p & ~q.sda_p & sda;   // see RULE2

  assign match_w = (q.sr[7:1] == q.own) ||          // see RULE11
                   (q.sr[7:1] == lrp_pkg::BCAST_ADDR); // see RULE12
  assign full_w  = q.out_v & q.skid_v;
  assign pop_w   = q.out_v & wr_ready;
  // Byte complete: on the falling edge, or still waiting while we stretch
  assign byte_w  = (q.bit_cnt == lrp_pkg::BYTE_BITS) && (fall_w || q.scl_oe);
  assign step_w  = q.settings[lrp_pkg::STEP_BIT] ? lrp_pkg::STEP_ONE : 8'h00; // see RULE18

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [7:0] tx_byte;
    tx_byte = (q.index == lrp_pkg::GEN_SET) ? q.settings : rd_data;
    d = q;
    d.rd_req = 1'b0;
    d.s1 = {addr_strap, alt_version, sda_i, scl_i};
    d.s2 = q.s1;
    d.scl_p = scl;
    d.sda_p = sda;

    // Strap caught once after reset release, after the syncs have filled
    if (q.cap != lrp_pkg::CAP_DONE)
    begin
      d.cap = q.cap + 2'h1;
      d.own = (q.s2[lrp_pkg::PIN_ALT] ? lrp_pkg::ALT_ADDR : lrp_pkg::BASE_ADDR)
              + {5'h00, q.s2[lrp_pkg::PIN_STRAP +: 2]};   // see RULE11
    end

    // Two-entry write buffer, drain side
    if (pop_w)
    begin
      if (q.skid_v)
      begin
        d.out = q.skid;
        d.skid_v = 1'b0;
      end
      else
      begin
        d.out_v = 1'b0;
      end
    end

    if (start_w)
    begin
      // Repeated START behaves like the first one
      d.state = lrp_pkg::ST_RX;                        // see RULE4
      d.kind = lrp_pkg::K_ADDR;                        // see RULE9
      d.bit_cnt = 4'h0;
      d.busy = 1'b1;                                   // see RULE4
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
      d.ld = 2'h0;
      d.wrote = 1'b0;
    end
    else if (stop_w)
    begin
      d.state = lrp_pkg::ST_IDLE;
      d.busy = 1'b0;                                   // see RULE4
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
      d.ld = 2'h0;
      d.wrote = 1'b0;
    end
    else
    begin
      case (q.state)
        lrp_pkg::ST_IDLE:
        begin
          d.sda_oe = 1'b0;
        end

        lrp_pkg::ST_RX:
        begin
          if (rise_w && q.bit_cnt != lrp_pkg::BYTE_BITS)
          begin
            d.sr = {q.sr[6:0], sda};                   // see RULE5
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
          else if (byte_w)
          begin
            case (q.kind)
              lrp_pkg::K_ADDR:
              begin
                if (match_w)
                begin
                  d.rw = q.sr[0];                      // see RULE9
                  d.sda_oe = 1'b1;                     // see RULE6
                  d.state = lrp_pkg::ST_ACK;
                end
                else
                begin
                  d.state = lrp_pkg::ST_IDLE;          // see RULE14
                end
              end
              lrp_pkg::K_INDEX:
              begin
                d.index = q.sr;                        // see RULE10
                d.sda_oe = 1'b1;                       // see RULE6
                d.state = lrp_pkg::ST_ACK;
              end
              default:
              begin
                // Buffer full: hold the clock low rather than drop the byte
                if (full_w)
                begin
                  d.scl_oe = 1'b1;
                end
                else
                begin
                  if (q.out_v && !pop_w)
                  begin
                    d.skid = '{addr: q.index, data: q.sr}; // see RULE10
                    d.skid_v = 1'b1;
                  end
                  else if (q.out_v)
                  begin
                    if (q.skid_v)
                    begin
                      d.skid = '{addr: q.index, data: q.sr};
                      d.skid_v = 1'b1;
                    end
                    else
                    begin
                      d.out = '{addr: q.index, data: q.sr};
                      d.out_v = 1'b1;
                    end
                  end
                  else
                  begin
                    d.out = '{addr: q.index, data: q.sr};
                    d.out_v = 1'b1;
                  end
                  if (q.index == lrp_pkg::GEN_SET)
                  begin
                    d.settings = q.sr;                 // see RULE18
                  end
                  d.wrote = 1'b1;
                  d.sda_oe = 1'b1;                     // see RULE6
                  d.state = lrp_pkg::ST_ACK;
                end
              end
            endcase
          end
        end

        lrp_pkg::ST_ACK:
        begin
          // Clock let go a cycle after the acknowledge is on the line
          if (q.scl_oe)
          begin
            d.scl_oe = 1'b0;                           // see RULE1
          end
          if (fall_w)
          begin
            d.sda_oe = 1'b0;                           // see RULE1
            d.bit_cnt = 4'h0;
            if (q.wrote)
            begin
              d.index = q.index + step_w;              // see RULE15
              d.wrote = 1'b0;                          // see RULE19
            end
            if (q.rw && q.kind == lrp_pkg::K_ADDR)
            begin
              d.state = lrp_pkg::ST_TX;                // see RULE16
              d.kind = lrp_pkg::K_DATA;
              d.ld = lrp_pkg::LD_CYC;
              d.rd_req = 1'b1;
            end
            else
            begin
              d.state = lrp_pkg::ST_RX;
              d.kind = (q.kind == lrp_pkg::K_ADDR) ? lrp_pkg::K_INDEX : lrp_pkg::K_DATA;
            end
          end
        end

        lrp_pkg::ST_TX:
        begin
          if (q.ld != 2'h0)
          begin
            d.ld = q.ld - 2'h1;
            if (q.ld == 2'h1)
            begin
              d.sr = tx_byte;                          // see RULE16
              d.sda_oe = ~tx_byte[7];                  // see RULE5
              d.bit_cnt = 4'h0;
            end
          end
          else if (fall_w)
          begin
            if (q.bit_cnt == lrp_pkg::LAST_BIT)
            begin
              d.sda_oe = 1'b0;
              d.state = lrp_pkg::ST_MACK;
            end
            else
            begin
              d.sr = {q.sr[6:0], 1'b0};
              d.sda_oe = ~q.sr[6];                     // see RULE1
              d.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end

        lrp_pkg::ST_MACK:
        begin
          if (rise_w)
          begin
            d.mack = ~sda;
          end
          else if (fall_w)
          begin
            if (q.mack)
            begin
              d.index = q.index + step_w;              // see RULE17
              d.ld = lrp_pkg::LD_CYC;
              d.rd_req = 1'b1;
              d.state = lrp_pkg::ST_TX;
            end
            else
            begin
              d.state = lrp_pkg::ST_IDLE;              // see RULE17
            end
          end
        end

        default:
        begin
          d.state = lrp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.settings <= lrp_pkg::GEN_RST;                  // see RULE18
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs; low data level only through the enables
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  assign wr_valid = q.out_v;
  assign wr_word = q.out;
  assign rd_req = q.rd_req;
  assign rd_addr = q.index;
  assign general_settings = q.settings;
  assign busy = q.busy;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_sda_edge: assert property ( // see RULE1
    $changed(q.sda_oe) |-> !$past(scl))
    else $error("data drive changed while clock high");

  chk_start_rx: assert property ( // see RULE2 see RULE4
    start_w |=> (q.state == lrp_pkg::ST_RX && q.bit_cnt == 4'h0 && q.kind == lrp_pkg::K_ADDR && q.busy))
    else $error("start did not restart address reception");

  chk_stop_idle: assert property ( // see RULE4
    stop_w |=> (q.state == lrp_pkg::ST_IDLE && !q.busy && !q.sda_oe))
    else $error("stop did not free the bus");

  chk_addr_miss: assert property ( // see RULE14
    (q.state == lrp_pkg::ST_RX && q.kind == lrp_pkg::K_ADDR && byte_w && !match_w && !start_w && !stop_w)
    |=> (q.state == lrp_pkg::ST_IDLE && !q.sda_oe) [*2])
    else $error("unmatched address was acknowledged");

  chk_ack_drive: assert property ( // see RULE6
    (q.state == lrp_pkg::ST_ACK) |-> q.sda_oe)
    else $error("acknowledge not driven");

  chk_write_step: assert property ( // see RULE15 see RULE19
    (q.state == lrp_pkg::ST_ACK && fall_w && q.wrote && !stop_w)
    |=> (q.index == $past(q.index) + $past(step_w)))
    else $error("write index step wrong");

  chk_read_step: assert property ( // see RULE17
    (q.state == lrp_pkg::ST_MACK && fall_w && q.mack && !stop_w)
    |=> (q.index == $past(q.index) + $past(step_w)) ##1 (q.ld == 2'h1))
    else $error("read index step or fetch wrong");

  chk_settings_wr: assert property ( // see RULE18
    (q.state == lrp_pkg::ST_RX && q.kind == lrp_pkg::K_DATA && byte_w && !full_w
     && q.index == lrp_pkg::GEN_SET && !start_w && !stop_w)
    |=> (q.settings == $past(q.sr)))
    else $error("settings register not written");

  chk_tx_msb: assert property ( // see RULE5
    (q.state == lrp_pkg::ST_TX && q.ld == 2'h0) |-> (q.sda_oe == ~q.sr[7]))
    else $error("transmit bit not the top of the shift register");

  cov_write: cover property (q.state == lrp_pkg::ST_ACK && q.wrote);
  cov_read: cover property (q.state == lrp_pkg::ST_MACK && fall_w && q.mack);
  cov_nomatch: cover property (q.state == lrp_pkg::ST_RX && q.kind == lrp_pkg::K_ADDR && byte_w && !match_w);
  cov_stretch: cover property (q.scl_oe);

endmodule

// ---- verif/lrp_host_model.sv ----
/*
  Bus controller model for the two-wire register port: START, STOP, byte
  send and receive at an 800 ns serial clock, made from mclk edges.
  Assumes open-drain wires with pull-ups, resolved in the bench.
*/
`timescale 1ns/100ps
module lrp_host_model
(
  input  wire logic mclk,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_lo,
  output logic      sda_lo,
  output logic      hang
);
  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    hang   = 1'b0;
  end

  // ==========================================================
  // Bit timing
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Stretch is honoured, but never for ever
  task automatic wait_high();
    int k;
    k = 0;
    while (!scl_i && k < 1000)
    begin
      @(posedge mclk);
      k++;
    end
    if (!scl_i)
      hang <= 1'b1;
  endtask

  // Low 6 cycles, high 2; the first read bit needs five low cycles
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_lo <= !b;
    tick(4);
    scl_lo <= 1'b0;
    wait_high();
    @(negedge mclk);
    r = sda_i;
    @(posedge mclk);
    scl_lo <= 1'b1;
  endtask

  // ==========================================================
  // Framing
  task automatic start();
    tick(2);
    sda_lo <= 1'b0;
    tick(3);
    scl_lo <= 1'b0;
    wait_high();
    tick(3);
    sda_lo <= 1'b1;
    tick(3);
    scl_lo <= 1'b1;
  endtask

  task automatic stop();
    tick(2);
    sda_lo <= 1'b1;
    tick(3);
    scl_lo <= 1'b0;
    wait_high();
    tick(3);
    sda_lo <= 1'b0;
    tick(6);
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Broadcast reads are only issued with one device present
  task automatic get(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// ---- verif/tb_top.sv ----
/*
  Self-checking bench of the two-wire register port: strap addressing,
  writes, reads, broadcast, write-buffer stall and index stepping.
  Assumes lrp_pkg and lrp_top; a register array stands behind the port.
*/
`timescale 1ns/100ps
module tb_top;
  logic             mclk;
  logic             arst_n;
  logic [1:0]       addr_strap;
  logic             alt_version;
  logic             wr_ready;
  logic             scl_lo, sda_lo, hang, scl_o, scl_oe, sda_o, sda_oe;
  logic             wr_valid, rd_req, busy;
  lrp_pkg::lrp_wr_t wr_word;
  logic [7:0]       rd_addr;
  logic [7:0]       general_settings;
  logic [7:0]       mem [256];
  wire logic        scl_w;
  wire logic        sda_w;
  wire logic [7:0]  rd_data;
  int               fails;
  int               check_count;

  // ==========================================================
  // Wires, register array, instances
  assign scl_w   = !(scl_lo || (scl_oe && !scl_o));
  assign sda_w   = !(sda_lo || (sda_oe && !sda_o));
  assign rd_data = mem[rd_addr];

  always @(posedge mclk)
    if (wr_valid && wr_ready)
      mem[wr_word.addr] <= wr_word.data;

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  lrp_top i_lrp_top (.mclk(mclk), .arst_n(arst_n), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(addr_strap), .alt_version(alt_version),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .general_settings(general_settings), .busy(busy));

  lrp_host_model i_lrp_host_model (.mclk(mclk), .scl_i(scl_w), .sda_i(sda_w), .scl_lo(scl_lo),
    .sda_lo(sda_lo), .hang(hang));

  // ==========================================================
  // Checking and closing
  task automatic conclude();
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge hang)
  begin
    fails++;
    conclude();
  end

  // ==========================================================
  // Transfers
  task automatic do_reset(input logic [1:0] s, input logic v);
    arst_n      <= 1'b0;
    addr_strap  <= s;
    alt_version <= v;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask

  task automatic probe(input logic [6:0] dev, input logic exp);
    logic a;
    i_lrp_host_model.start();
    i_lrp_host_model.put({dev, 1'b0}, a);
    chk({7'h0, busy}, 8'h01);
    i_lrp_host_model.stop();
    chk({7'h0, busy}, 8'h00);
    chk({7'h0, a}, {7'h0, exp});
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] idx, input logic [23:0] d, input int n);
    logic a;
    i_lrp_host_model.start();
    i_lrp_host_model.put({dev, 1'b0}, a);
    chk({7'h0, a}, 8'h01);
    i_lrp_host_model.put(idx, a);
    chk({7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      i_lrp_host_model.put(d[23 - 8 * i -: 8], a);
      chk({7'h0, a}, 8'h01);
    end
    i_lrp_host_model.stop();
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] idx, input logic [23:0] e, input int n);
    logic       a;
    logic [7:0] b;
    i_lrp_host_model.start();
    i_lrp_host_model.put({dev, 1'b0}, a);
    i_lrp_host_model.put(idx, a);
    i_lrp_host_model.start();
    i_lrp_host_model.put({dev, 1'b1}, a);
    chk({7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      i_lrp_host_model.get(b, i < n - 1);
      chk(b, e[23 - 8 * i -: 8]);
    end
    i_lrp_host_model.stop();
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    arst_n      = 1'b0;
    addr_strap  = 2'h0;
    alt_version = 1'b0;
    wr_ready    = 1'b1;
    fails       = 0;
    check_count = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
    for (int v = 0; v < 2; v++)
      for (int s = 0; s < 4; s++)
      begin
        do_reset(s[1:0], v[0]);
        chk(general_settings, 8'h01);
        probe(7'(8'h32 + 8'h10 * v + s), 1'b1);
        probe(7'(8'h42 - 8'h10 * v + s), 1'b0);
        probe(7'h40, 1'b1);
      end
    wr(7'h45, 8'h10, 24'hA55A3C, 3);
    chk(mem[8'h12], 8'h3C);
    rd(7'h45, 8'h10, 24'hA55A3C, 3);
    wr(7'h40, 8'h20, 24'h770000, 1);
    rd(7'h40, 8'h20, 24'h770000, 1);
    // Sink stalls: two words park in the buffer, the third holds the clock
    wr_ready <= 1'b0;
    fork
      wr(7'h45, 8'h30, 24'h112233, 3);
      begin
        repeat (450) @(posedge mclk);
        chk({6'h0, scl_oe, wr_valid}, 8'h03);
        wr_ready <= 1'b1;
      end
    join
    rd(7'h45, 8'h30, 24'h112233, 3);
    wr(7'h45, 8'h2F, 24'h000000, 1);
    chk(general_settings, 8'h00);
    wr(7'h45, 8'h50, 24'hABCD00, 2);
    chk(mem[8'h50], 8'hCD);
    chk(mem[8'h51], 8'h00);
    rd(7'h45, 8'h50, 24'hCDCD00, 2);
    // Mid-run reset brings stepping back on
    do_reset(2'h3, 1'b1);
    chk(general_settings, 8'h01);
    wr(7'h45, 8'h60, 24'h5AA500, 2);
    chk(mem[8'h61], 8'hA5);
    conclude();
  end
endmodule
